/* File: pkg/cag_defs.svh */
// Constants for the CPU address generation block.
// Assumes inclusion by bare name from the package and the design modules.
// Functional notes
// [RQ1] Sequential fetch advances the program counter by instruction byte length.
// [RQ2] Relative branch adds displacement to the next instruction's address.
// [RQ3] Displacement is signed two's complement, bit 7 sign, -128 to +127.
// [RQ4] Sign extension fills upper bits with copies of the sign bit.
// [RQ5] Short unconditional and all conditional branches use relative targets.
// [RQ6] Absolute 16-bit call and branch load the immediate target directly.
// [RQ7] Short fixed call targets only the region 0800H to 0FFFH.
// [RQ8] Table call takes opcode bits 1 to 5 to pick a vector at 40H-7FH.
// [RQ9] Register-indirect branch copies pair AX into the program counter.
// [RQ10] Unsigned multiply takes A as multiplicand and writes product to AX.
// [RQ11] Unsigned word divide reads dividend from AX and writes quotient to AX.
// [RQ12] Decimal adjust and nibble rotates implicitly operate on register A.
// [RQ13] Register operand chosen from both bank flags plus the register code.
// [RQ14] X,A,C,B,E,D,L,H map to indices 0-7; AX,BC,DE,HL to pairs 0-3.
// [RQ15] Direct addressing uses the 16-bit immediate as effective address.
// [RQ16] Short direct reaches a fixed 256-byte window FE20H through FF1FH.
// [RQ17] Short direct bit 8 is 0 for fields 20H-FFH, 1 for 00H-1FH.
// [RQ18] FE20H-FEFFH is high-speed RAM, FF00H-FF1FH is special registers.
// [RQ19] External access area is reachable only through direct addressing.
// [RQ20] Special register addressing reaches FF00H-FFCFH and FFE0H-FFFFH only.
// [RQ21] Short direct forces bits 15 to 9 to ones, low byte from field.
`ifndef CAG_DEFS_SVH
`define CAG_DEFS_SVH

`define CAG_PC_RESET 16'h0000
`define CAG_FIXED_CALL_BASE 16'h0800
`define CAG_VECTOR_BASE 16'h0040
`define CAG_SHORT_HI_BITS 7'h7f
`define CAG_SHORT_SFR_LIMIT 8'h20
`define CAG_RAM_LO 16'hfe20
`define CAG_RAM_HI 16'hfeff
`define CAG_SFR_LO 16'hff00
`define CAG_SFR_TOP 8'hff
`define CAG_EXT_LO 8'hd0
`define CAG_EXT_HI 8'hdf
`define CAG_BANK_SHIFT 5
`define CAG_REG_A 3'h1
`define CAG_PAIR_AX 2'h0
`define CAG_LEN_MIN 3'h1
`define CAG_LEN_MAX 3'h4

`endif

/* File: pkg/cag_pkg.sv */
// Types for the CPU address generation block.
// Assumes the constants header sits on the include path.
`include "cag_defs.svh"

package cag_pkg;

    // Program counter source per executed instruction
    typedef enum logic [2:0] {
        CAG_PC_SEQ,
        CAG_PC_REL,
        CAG_PC_ABS16,
        CAG_PC_FIXED11,
        CAG_PC_VECTOR,
        CAG_PC_REG_AX
    } cag_pc_mode_t;

    // Operand addressing kind
    typedef enum logic [2:0] {
        CAG_OP_NONE,
        CAG_OP_IMPLIED,
        CAG_OP_REG8,
        CAG_OP_REG16,
        CAG_OP_DIRECT,
        CAG_OP_SHORT,
        CAG_OP_SFR
    } cag_op_mode_t;

    // Implied-operand instruction classes
    typedef enum logic [2:0] {
        CAG_IMP_MULTIPLY,
        CAG_IMP_DIVIDE,
        CAG_IMP_ADJUST_ADD,
        CAG_IMP_ADJUST_SUB,
        CAG_IMP_ROTATE_RIGHT,
        CAG_IMP_ROTATE_LEFT
    } cag_imp_op_t;

    // Memory region the operand address lands in
    typedef enum logic [1:0] {
        CAG_REGION_MEMORY,
        CAG_REGION_HS_RAM,
        CAG_REGION_SFR,
        CAG_REGION_REG_BANK
    } cag_region_t;

    // Decoded instruction fields presented by the sequencer
    typedef struct packed {
        logic [2:0] length;
        logic [7:0] opcode;
        logic [7:0] branch_displacement;
        logic [15:0] imm16;
        logic [10:0] imm11;
        logic [7:0] imm8;
        logic [2:0] reg_code;
        logic [1:0] pair_code;
    } cag_insn_t;

    // Operand address result
    typedef struct packed {
        logic [15:0] addr;
        cag_region_t region;
        logic is_pair;
        logic writes_pair;
        logic illegal;
    } cag_operand_t;

endpackage

/* File: rtl/cag_pc_target.sv */
// Combinational branch target former for the program counter.
// Assumes the vector word has already been fetched from the table.
`include "cag_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module cag_pc_target
    import cag_pkg::*;
(
    // Current state
    input wire logic [15:0] pc,
    input wire cag_pc_mode_t mode,
    input wire cag_insn_t insn,
    // Sources
    input wire logic [15:0] pair_ax,
    input wire logic [15:0] vector_word,
    // Result
    output logic [15:0] target,
    output logic [15:0] vector_addr
);
    logic [15:0] next_seq;
    logic [15:0] disp_ext;

    // [RQ1] Advance by length
    assign next_seq = pc + {13'h0000, insn.length};
    // [RQ3] [RQ4] Sign extension
    assign disp_ext = {{8{insn.branch_displacement[7]}}, insn.branch_displacement};
    // [RQ8] Vector slot pick
    assign vector_addr = `CAG_VECTOR_BASE | {10'h000, insn.opcode[5:1], 1'b0};

    always_comb begin
        case (mode)
            // [RQ2] [RQ5] Relative target
            CAG_PC_REL: target = next_seq + disp_ext;
            // [RQ6] Absolute load
            CAG_PC_ABS16: target = insn.imm16;
            // [RQ7] Fixed area call
            CAG_PC_FIXED11: target = `CAG_FIXED_CALL_BASE | {5'h00, insn.imm11};
            // [RQ8] Vector load
            CAG_PC_VECTOR: target = vector_word;
            // [RQ9] Pair AX copy
            CAG_PC_REG_AX: target = pair_ax;
            default: target = next_seq;
        endcase
    end

endmodule

`default_nettype wire

/* File: rtl/cag_operand_addr.sv */
// Combinational operand effective address former.
// Assumes the general registers sit in a bank area addressed by index.
`include "cag_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module cag_operand_addr
    import cag_pkg::*;
(
    // Selection
    input wire cag_op_mode_t mode,
    input wire cag_insn_t insn,
    input wire logic bank_select_low,
    input wire logic bank_select_high,
    input wire cag_imp_op_t imp_op,
    // Result
    output cag_operand_t result
);
    logic [1:0] bank;
    logic [15:0] bank_base;

    // [RQ13] Bank from both flags
    assign bank = {bank_select_high, bank_select_low};
    assign bank_base = {11'h000, bank, 3'h0} << 1;

    always_comb begin
        result = '0;
        result.region = CAG_REGION_MEMORY;
        case (mode)
            CAG_OP_IMPLIED: begin
                result.region = CAG_REGION_REG_BANK;
                // [RQ10] [RQ11] [RQ12] Implied accumulator
                if (imp_op == CAG_IMP_MULTIPLY || imp_op == CAG_IMP_DIVIDE) begin
                    result.addr = bank_base | {14'h0000, `CAG_PAIR_AX};
                    result.is_pair = 1'b1;
                    result.writes_pair = 1'b1;
                end else begin
                    result.addr = bank_base | {13'h0000, `CAG_REG_A};
                end
            end
            CAG_OP_REG8: begin
                // [RQ13] [RQ14] Byte register index
                result.region = CAG_REGION_REG_BANK;
                result.addr = bank_base | {13'h0000, insn.reg_code};
            end
            CAG_OP_REG16: begin
                // [RQ14] Pair index
                result.region = CAG_REGION_REG_BANK;
                result.addr = bank_base | {13'h0000, insn.pair_code, 1'b0};
                result.is_pair = 1'b1;
            end
            CAG_OP_DIRECT: begin
                // [RQ15] [RQ19] Full 16-bit reach
                result.addr = insn.imm16;
                if (insn.imm16 >= `CAG_RAM_LO && insn.imm16 <= `CAG_RAM_HI) begin
                    result.region = CAG_REGION_HS_RAM;
                end else if (insn.imm16 >= `CAG_SFR_LO) begin
                    result.region = CAG_REGION_SFR;
                end
            end
            CAG_OP_SHORT: begin
                // [RQ16] [RQ17] [RQ21] Short window
                result.addr = {`CAG_SHORT_HI_BITS,
                               (insn.imm8 < `CAG_SHORT_SFR_LIMIT), insn.imm8};
                // [RQ18] Window split
                if (insn.imm8 < `CAG_SHORT_SFR_LIMIT) begin
                    result.region = CAG_REGION_SFR;
                end else begin
                    result.region = CAG_REGION_HS_RAM;
                end
            end
            CAG_OP_SFR: begin
                // [RQ20] [RQ19] External area refused
                result.addr = {`CAG_SFR_TOP, insn.imm8};
                result.region = CAG_REGION_SFR;
                result.illegal = (insn.imm8 >= `CAG_EXT_LO && insn.imm8 <= `CAG_EXT_HI);
            end
            default: begin
                result.addr = 16'h0000;
            end
        endcase
    end

endmodule

`default_nettype wire

/* File: rtl/cag_top.sv */
// Address generation core: program counter and operand address registers.
// Assumes the sequencer presents decoded fields with a one-cycle step strobe.
`include "cag_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module cag_top
    import cag_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Instruction step
    input wire logic step,
    input wire cag_insn_t insn,
    input wire cag_pc_mode_t pc_mode,
    input wire cag_op_mode_t op_mode,
    input wire cag_imp_op_t imp_op,
    // Register state
    input wire logic bank_select_low,
    input wire logic bank_select_high,
    input wire logic [15:0] pair_ax,
    input wire logic [15:0] vector_word,
    // Results
    output logic [15:0] pc,
    output logic [15:0] vector_addr,
    output cag_operand_t operand,
    output logic length_error
);
    logic [15:0] pc_ff;
    logic [15:0] vec_ff;
    cag_operand_t op_ff;
    logic len_err_ff;
    logic [15:0] nxt_pc;
    logic [15:0] nxt_vec;
    cag_operand_t nxt_op;
    logic len_bad;

    cag_pc_target u_target (
        .pc(pc_ff),
        .mode(pc_mode),
        .insn(insn),
        .pair_ax(pair_ax),
        .vector_word(vector_word),
        .target(nxt_pc),
        .vector_addr(nxt_vec)
    );

    cag_operand_addr u_operand (
        .mode(op_mode),
        .insn(insn),
        .bank_select_low(bank_select_low),
        .bank_select_high(bank_select_high),
        .imp_op(imp_op),
        .result(nxt_op)
    );

    // Lengths outside 1..4 would stall or skip code
    assign len_bad = (insn.length < `CAG_LEN_MIN) || (insn.length > `CAG_LEN_MAX);

    // [RQ1] Program counter update
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pc_ff <= `CAG_PC_RESET;
        end else if (step && !len_bad) begin
            pc_ff <= nxt_pc;
        end
    end

    // [RQ8] Vector fetch address
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            vec_ff <= 16'h0000;
        end else if (step) begin
            vec_ff <= nxt_vec;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            op_ff <= '0;
        end else if (step) begin
            op_ff <= nxt_op;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            len_err_ff <= 1'b0;
        end else if (step) begin
            len_err_ff <= len_bad;
        end
    end

    assign pc = pc_ff;
    assign vector_addr = vec_ff;
    assign operand = op_ff;
    assign length_error = len_err_ff;

endmodule

`default_nettype wire

/* File: bench/cag_top_asserts.sv */
// Port checker for the address generation core.
// Assumes a bind onto cag_top; one clock domain.
`timescale 1ns/100ps
`default_nettype none

module cag_top_asserts
    import cag_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Step inputs
    input wire logic step,
    input wire cag_insn_t insn,
    input wire cag_pc_mode_t pc_mode,
    input wire cag_op_mode_t op_mode,
    input wire cag_imp_op_t imp_op,
    input wire logic [15:0] pair_ax,
    input wire logic [15:0] vector_word,
    // Results
    input wire logic [15:0] pc,
    input wire cag_operand_t operand,
    input wire logic length_error
);
    logic go;
    logic ax_op;
    logic [15:0] seq_next;
    logic [15:0] rel_next;
    logic [7:0] f8;

    assign go = step && insn.length >= 3'h1 && insn.length <= 3'h4;
    // Multiply and divide are the classes that use the AX pair
    assign ax_op = imp_op == CAG_IMP_MULTIPLY || imp_op == CAG_IMP_DIVIDE;
    assign seq_next = pc + {13'h0000, insn.length};
    assign rel_next = seq_next + {{8{insn.branch_displacement[7]}}, insn.branch_displacement};
    assign f8 = insn.imm8;

    default clocking @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    chk_seq_advance: assert property (go && pc_mode == CAG_PC_SEQ |=>
        pc == $past(seq_next))
        else $error("pc did not advance by length");
    chk_rel_target: assert property (go && pc_mode == CAG_PC_REL |=>
        pc == $past(rel_next))
        else $error("relative target wrong");
    chk_abs_load: assert property (go && pc_mode == CAG_PC_ABS16 |=>
        pc == $past(insn.imm16))
        else $error("absolute target wrong");
    chk_fixed_area: assert property (go && pc_mode == CAG_PC_FIXED11 |=>
        pc[15:11] == 5'h01)
        else $error("fixed call outside area");
    chk_vector_load: assert property (go && pc_mode == CAG_PC_VECTOR |=>
        pc == $past(vector_word))
        else $error("vector word not loaded");
    chk_ax_load: assert property (go && pc_mode == CAG_PC_REG_AX |=>
        pc == $past(pair_ax))
        else $error("pair value not loaded");
    chk_direct_addr: assert property (step && op_mode == CAG_OP_DIRECT |=>
        operand.addr == $past(insn.imm16))
        else $error("direct address wrong");
    chk_short_window: assert property (step && op_mode == CAG_OP_SHORT |=>
        operand.addr == {7'h7f, $past(f8) < 8'h20, $past(f8)})
        else $error("short address wrong");
    chk_short_high: assert property (step && op_mode == CAG_OP_SHORT |=>
        operand.addr[15:9] == 7'h7f)
        else $error("short high bits not ones");
    chk_short_split: assert property (step && op_mode == CAG_OP_SHORT |=>
        operand.region == ($past(f8) < 8'h20 ? CAG_REGION_SFR : CAG_REGION_HS_RAM))
        else $error("short window split wrong");
    chk_sfr_page: assert property (step && op_mode == CAG_OP_SFR |=>
        operand.addr == {8'hff, $past(f8)})
        else $error("sfr page address wrong");
    chk_ext_refused: assert property (step && op_mode == CAG_OP_SFR && f8[7:4] == 4'hd |=>
        operand.illegal)
        else $error("external area not refused");
    chk_byte_reg: assert property (step && op_mode == CAG_OP_REG8 |=>
        operand.region == CAG_REGION_REG_BANK && operand.addr[2:0] == $past(insn.reg_code))
        else $error("byte register index wrong");
    chk_pair_index: assert property (step && op_mode == CAG_OP_REG16 |=>
        operand.is_pair && operand.addr[2:0] == {$past(insn.pair_code), 1'b0})
        else $error("pair index wrong");
    chk_implied_acc: assert property (step && op_mode == CAG_OP_IMPLIED |=>
        operand.region == CAG_REGION_REG_BANK && operand.is_pair == $past(ax_op))
        else $error("implied accumulator wrong");
    chk_len_hold: assert property (step && !go |=> length_error && $stable(pc))
        else $error("bad length not held");

    cover property (go && pc_mode == CAG_PC_REL && insn.branch_displacement[7]);
    cover property (step && op_mode == CAG_OP_SHORT && f8 < 8'h20);
    cover property (step && op_mode == CAG_OP_IMPLIED && ax_op);
    cover property (step && !go);
endmodule

bind cag_top cag_top_asserts u_chk (.mclk(mclk), .reset_n(reset_n), .step(step), .insn(insn),
    .pc_mode(pc_mode), .op_mode(op_mode), .imp_op(imp_op), .pair_ax(pair_ax),
    .vector_word(vector_word), .pc(pc), .operand(operand), .length_error(length_error));

`default_nettype wire

/* File: bench/cag_top_tb.sv */
// Self-checking bench for the address generation core.
// Assumes the checker file is compiled alongside.
`timescale 1ns/100ps
`default_nettype none

module cag_top_tb;
    import cag_pkg::*;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic step = 1'b0;
    cag_insn_t insn = '0;
    cag_pc_mode_t pm = CAG_PC_SEQ;
    cag_op_mode_t om = CAG_OP_NONE;
    cag_imp_op_t imp_op = CAG_IMP_MULTIPLY;
    logic bank_select_low = 1'b0;
    logic bank_select_high = 1'b0;
    logic [15:0] pair_ax = 16'h8e3c;
    logic [15:0] vector_word = 16'ha5c3;
    logic [15:0] pc;
    logic [15:0] vector_addr;
    cag_operand_t operand;
    logic length_error;
    int miscompares = 0;
    int comparisons = 0;

    cag_top uut (.mclk(mclk), .reset_n(reset_n), .step(step), .insn(insn), .pc_mode(pm),
        .op_mode(om), .imp_op(imp_op), .bank_select_low(bank_select_low),
        .bank_select_high(bank_select_high), .pair_ax(pair_ax), .vector_word(vector_word),
        .pc(pc), .vector_addr(vector_addr), .operand(operand), .length_error(length_error));

    initial begin
        forever #25 mclk = ~mclk;
    end

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One-cycle step; results settle by the next falling edge
    task automatic go(input cag_pc_mode_t p, input cag_op_mode_t o);
        @(negedge mclk);
        pm = p;
        om = o;
        step = 1'b1;
        @(negedge mclk);
        step = 1'b0;
    endtask

    task automatic t_branch;
        logic [7:0] d[3] = '{8'hfe, 8'h80, 8'h7f};
        logic [15:0] e[3] = '{16'h1000, 16'h0f82, 16'h1081};
        insn.length = 3'h3;
        for (int i = 1; i <= 4; i++) begin
            insn.length = i[2:0];
            go(CAG_PC_SEQ, CAG_OP_NONE);
            cmp(pc, 16'(i * (i + 1) / 2));
        end
        for (int i = 0; i < 3; i++) begin
            insn.imm16 = 16'h1000;
            go(CAG_PC_ABS16, CAG_OP_NONE);
            insn.length = 3'h2;
            insn.branch_displacement = d[i];
            go(CAG_PC_REL, CAG_OP_NONE);
            cmp(pc, e[i]);
        end
        insn.imm16 = 16'hffff;
        go(CAG_PC_ABS16, CAG_OP_NONE);
        cmp(pc, 16'hffff);
        go(CAG_PC_REG_AX, CAG_OP_NONE);
        cmp(pc, 16'h8e3c);
        insn.imm11 = 11'h123;
        go(CAG_PC_FIXED11, CAG_OP_NONE);
        cmp(pc, 16'h0923);
        insn.opcode = 8'hff;
        go(CAG_PC_VECTOR, CAG_OP_NONE);
        cmp(pc, 16'ha5c3);
        cmp(vector_addr, 16'h007e);
        insn.length = 3'h0;
        go(CAG_PC_SEQ, CAG_OP_NONE);
        cmp({15'h0, length_error}, 16'h0001);
        cmp(pc, 16'ha5c3);
        $display("test branch done");
    endtask

    task automatic t_operand;
        logic [7:0] f[4] = '{8'h00, 8'h1f, 8'h20, 8'hff};
        logic [15:0] a[4] = '{16'hff00, 16'hff1f, 16'hfe20, 16'hfeff};
        insn.length = 3'h2;
        for (int i = 0; i < 4; i++) begin
            insn.imm8 = f[i];
            go(CAG_PC_SEQ, CAG_OP_SHORT);
            cmp(operand.addr, a[i]);
            cmp({14'h0, operand.region}, i < 2 ? 16'h0002 : 16'h0001);
        end
        insn.imm8 = 8'hd0;
        go(CAG_PC_SEQ, CAG_OP_SFR);
        cmp({15'h0, operand.illegal}, 16'h0001);
        insn.imm8 = 8'he0;
        go(CAG_PC_SEQ, CAG_OP_SFR);
        cmp({15'h0, operand.illegal}, 16'h0000);
        cmp(operand.addr, 16'hffe0);
        insn.imm16 = 16'h1234;
        go(CAG_PC_SEQ, CAG_OP_DIRECT);
        cmp(operand.addr, 16'h1234);
        cmp({14'h0, operand.region}, 16'h0000);
        // External area stays reachable through direct addressing
        insn.imm16 = 16'hffd5;
        go(CAG_PC_SEQ, CAG_OP_DIRECT);
        cmp(operand.addr, 16'hffd5);
        cmp({15'h0, operand.illegal}, 16'h0000);
        // Bank area is sixteen bytes per bank in this core
        bank_select_high = 1'b1;
        insn.reg_code = 3'h3;
        go(CAG_PC_SEQ, CAG_OP_REG8);
        cmp(operand.addr, 16'h0023);
        cmp({14'h0, operand.region}, 16'h0003);
        bank_select_low = 1'b1;
        insn.pair_code = 2'h3;
        go(CAG_PC_SEQ, CAG_OP_REG16);
        cmp(operand.addr, 16'h0036);
        go(CAG_PC_SEQ, CAG_OP_IMPLIED);
        cmp({14'h0, operand.writes_pair, operand.is_pair}, 16'h0003);
        cmp(operand.addr, 16'h0030);
        imp_op = CAG_IMP_DIVIDE;
        go(CAG_PC_SEQ, CAG_OP_IMPLIED);
        cmp({14'h0, operand.writes_pair, operand.is_pair}, 16'h0003);
        cmp(operand.addr, 16'h0030);
        imp_op = CAG_IMP_ADJUST_ADD;
        go(CAG_PC_SEQ, CAG_OP_IMPLIED);
        cmp({14'h0, operand.writes_pair, operand.is_pair}, 16'h0000);
        cmp(operand.addr, 16'h0031);
        imp_op = CAG_IMP_ROTATE_LEFT;
        go(CAG_PC_SEQ, CAG_OP_IMPLIED);
        cmp(operand.addr, 16'h0031);
        $display("test operand done");
    endtask

    task automatic end_of_test;
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Whole run is well under 200 steps
    initial begin
        #40000;
        miscompares++;
        end_of_test;
    end

    initial begin
        repeat (12) @(negedge mclk);
        reset_n = 1'b1;
        cmp(pc, 16'h0000);
        t_branch;
        t_operand;
        end_of_test;
    end
endmodule

`default_nettype wire
